// *** include/arl_pkg.sv ***
// Constants and carrier types for the address register and memory layout block
// Notes on behaviour
// - Address registers and stack pointers are 32 bits.
// - Byte size refused on address registers.
// - Word source uses low half only.
// - Destination write always updates all bits.
// - Word operands sign-extend to 32 bits.
// - High byte at even, low at odd.
// - Word and long accesses only at even addresses.
// - Long word: high word n, low n+2.
// - Two BCD digits per byte, high nibble first.
// - Byte-wide bus gives identical memory layout.
// - Stop halts execution until an interrupt.
// - False condition without else changes nothing.
// - Stack pointer byte step is two.
package arl_pkg;
  localparam int AW = 32;
  localparam int NREG = 8;
  localparam int SP_IDX = 7;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG = 32'h0000_0004;
  localparam logic [31:0] LONG_HALF = 32'h0000_0002;
  localparam int WORD_MSB = 15;

  typedef enum logic [1:0] {
    ARL_SZ_BYTE = 2'b00,
    ARL_SZ_WORD = 2'b01,
    ARL_SZ_LONG = 2'b10
  } arl_size_t;

  typedef enum logic [1:0] {
    ARL_AM_NONE = 2'b00,
    ARL_AM_POSTINC = 2'b01,
    ARL_AM_PREDEC = 2'b10
  } arl_amode_t;

  // One register operation request
  typedef struct packed {
    logic        wr;
    logic        cond_op;
    logic        cond_true;
    logic        has_else;
    logic [2:0]  idx;
    arl_size_t   size;
    arl_amode_t  amode;
    logic [31:0] data;
  } arl_req_t;

  // One memory access request
  typedef struct packed {
    logic        fetch;
    logic        wr;
    arl_size_t   size;
    logic [31:0] addr;
    logic [31:0] data;
  } arl_mreq_t;
endpackage : arl_pkg

// *** core/arl_core.sv ***
// Address register file, memory layout sequencer, stop and conditional control
`timescale 1ns/1ps
module arl_core #(
  parameter int MEM_BUS_W = 16              // 16 or 8 bit external data bus
) (
  input  wire logic              clk_i,     // 40 MHz clock
  input  wire logic              rst_n_i,   // Async reset, active low
  input  wire logic              req_vld_i, // Register request strobe
  input  wire arl_pkg::arl_req_t req_i,     // Register request
  input  wire logic              supv_i,    // Supervisor mode selects stack
  input  wire logic [2:0]        rd_idx_i,  // Read port index
  input  wire arl_pkg::arl_size_t rd_size_i, // Read size
  output logic [31:0]            rd_data_o, // Read operand
  output logic                   size_err_o, // Byte size on register refused
  input  wire logic              mreq_vld_i, // Memory request strobe
  input  wire arl_pkg::arl_mreq_t mreq_i,   // Memory request
  output logic                   mreq_rdy_o, // Sequencer idle and not stopped
  output logic                   align_err_o, // Odd multibyte access refused
  output logic                   mem_vld_o, // Bus cycle strobe
  output logic [31:0]            mem_addr_o, // Bus byte address
  output logic                   mem_wr_o,  // Bus cycle is a write
  output logic [MEM_BUS_W-1:0]   mem_wdata_o, // Bus write data
  input  wire logic [MEM_BUS_W-1:0] mem_rdata_i, // Bus read data
  input  wire logic              mem_ack_i, // Bus cycle done
  output logic                   rdone_o,   // Read data ready
  output logic [31:0]            rdata_o,   // Assembled read data
  input  wire logic [7:0]        bcd_i,     // Packed decimal byte
  output logic [3:0]             most_significant_digit_o,  // Upper digit
  output logic [3:0]             least_significant_digit_o, // Lower digit
  input  wire logic              stop_i,    // Stop operation executed
  input  wire logic              irq_i,     // Interrupt pin
  output logic                   stopped_o  // Execution halted
);
  localparam int BW = MEM_BUS_W / 8;
  if (MEM_BUS_W != 16 && MEM_BUS_W != 8) begin : g_bus_w_chk
    $error("MEM_BUS_W must be 8 or 16");
  end

  ////////////////////////////////////////////////////////////////////////
  logic rst_m;
  logic rst_n;
  logic irq_m;
  logic irq_s;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
      irq_m <= 1'b0;
      irq_s <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
      irq_m <= irq_i;
      irq_s <= irq_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers 0..6 plus both stack pointers
  logic [arl_pkg::AW-1:0] areg [arl_pkg::NREG];
  logic [arl_pkg::AW-1:0] user_stack_pointer;
  logic [arl_pkg::AW-1:0] supervisor_stack_pointer;
  logic [arl_pkg::AW-1:0] next_areg;

  wire is_sp       = (req_i.idx == 3'(arl_pkg::SP_IDX));
  wire is_byte     = (req_i.size == arl_pkg::ARL_SZ_BYTE);
  wire byte_direct = is_byte && (req_i.amode == arl_pkg::ARL_AM_NONE);
  wire cond_skip   = req_i.cond_op && !req_i.cond_true && !req_i.has_else;
  wire do_req      = req_vld_i && !stopped_o && !cond_skip && !byte_direct;
  wire [31:0] cur  = is_sp ? (supv_i ? supervisor_stack_pointer : user_stack_pointer)
                           : areg[req_i.idx];
  wire [31:0] sext_in = {{16{req_i.data[arl_pkg::WORD_MSB]}}, req_i.data[15:0]};
  wire [31:0] step = (req_i.size == arl_pkg::ARL_SZ_LONG) ? arl_pkg::STEP_LONG :
                     (req_i.size == arl_pkg::ARL_SZ_WORD || is_sp) ? arl_pkg::STEP_WORD
                                                                   : arl_pkg::STEP_BYTE;

  always_comb begin
    case (req_i.amode)
      arl_pkg::ARL_AM_POSTINC: next_areg = cur + step;
      arl_pkg::ARL_AM_PREDEC:  next_areg = cur - step;
      default: next_areg = (req_i.size == arl_pkg::ARL_SZ_WORD) ? sext_in : req_i.data;
    endcase
  end

  wire reg_wr = do_req && (req_i.wr || req_i.amode != arl_pkg::ARL_AM_NONE);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < arl_pkg::NREG; i++) areg[i] <= arl_pkg::ZERO32;
      user_stack_pointer       <= arl_pkg::ZERO32;
      supervisor_stack_pointer <= arl_pkg::ZERO32;
      size_err_o               <= 1'b0;
    end else begin
      size_err_o <= req_vld_i && !stopped_o && !cond_skip && byte_direct;
      if (reg_wr) begin
        if (!is_sp) areg[req_i.idx] <= next_areg;
        else if (supv_i) supervisor_stack_pointer <= next_areg;
        else user_stack_pointer <= next_areg;
      end
    end
  end

  wire [31:0] rd_full = (rd_idx_i == 3'(arl_pkg::SP_IDX))
                      ? (supv_i ? supervisor_stack_pointer : user_stack_pointer) : areg[rd_idx_i];
  // Word read gives the sign-extended low half
  assign rd_data_o = (rd_size_i == arl_pkg::ARL_SZ_LONG) ? rd_full
                   : {{16{rd_full[arl_pkg::WORD_MSB]}}, rd_full[15:0]};

  ////////////////////////////////////////////////////////////////////////
  // Stop state
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) stopped_o <= 1'b0;
    else if (irq_s) stopped_o <= 1'b0;
    else if (stop_i) stopped_o <= 1'b1;
  end

  // Packed decimal split
  assign most_significant_digit_o  = bcd_i[7:4];
  assign least_significant_digit_o = bcd_i[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Memory sequencer: big-endian split into bus-width beats
  typedef enum logic [1:0] {
    ARL_ST_IDLE = 2'b00,
    ARL_ST_BUSY = 2'b01
  } arl_state_t;
  arl_state_t state;
  logic [2:0]  beats_left;
  logic [31:0] addr;
  logic [31:0] wbuf;
  logic [31:0] rbuf;
  logic        wr_q;
  logic        single;

  wire multi   = (mreq_i.size != arl_pkg::ARL_SZ_BYTE) || mreq_i.fetch;
  wire odd_bad = multi && mreq_i.addr[0];
  wire take    = mreq_vld_i && (state == ARL_ST_IDLE) && !stopped_o;
  wire [2:0] nbytes = (mreq_i.size == arl_pkg::ARL_SZ_LONG) ? 3'd4 :
                      (multi ? 3'd2 : 3'd1);
  wire [2:0] nbeats = (BW == 2 && nbytes != 3'd1) ? (nbytes >> 1) : nbytes;
  // Left-justify write data so the top byte goes first
  wire [31:0] wjust = (nbytes == 3'd4) ? mreq_i.data :
                      (nbytes == 3'd2) ? {mreq_i.data[15:0], 16'h0000} : {mreq_i.data[7:0], 24'h0000_00};
  wire byte_beat = (BW == 1) || (nbytes == 3'd1);

  assign mreq_rdy_o = (state == ARL_ST_IDLE) && !stopped_o;
  assign mem_vld_o  = (state == ARL_ST_BUSY);
  assign mem_addr_o = addr;
  assign mem_wr_o   = wr_q;

  // Lane from the latched size, the request lines may move on mid-transfer
  always_comb begin
    if (BW == 2)
      mem_wdata_o = MEM_BUS_W'(single && addr[0] ? {8'h00, wbuf[31:24]} :
                               single ? {wbuf[31:24], 8'h00} : wbuf[31:16]);
    else
      mem_wdata_o = MEM_BUS_W'(wbuf[31:24]);
  end

  logic [7:0]  rb8;
  logic [15:0] rb16;
  always_comb begin
    rb8  = 8'h00;
    rb16 = 16'h0000;
    if (BW == 2) begin
      rb16 = 16'(mem_rdata_i);
      rb8  = addr[0] ? rb16[7:0] : rb16[15:8];
    end else begin
      rb8 = mem_rdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state       <= ARL_ST_IDLE;
      beats_left  <= 3'd0;
      addr        <= arl_pkg::ZERO32;
      wbuf        <= arl_pkg::ZERO32;
      rbuf        <= arl_pkg::ZERO32;
      wr_q        <= 1'b0;
      single      <= 1'b0;
      align_err_o <= 1'b0;
      rdone_o     <= 1'b0;
      rdata_o     <= arl_pkg::ZERO32;
    end else begin
      align_err_o <= take && odd_bad;
      rdone_o     <= 1'b0;
      case (state)
        ARL_ST_IDLE: begin
          if (take && !odd_bad) begin
            state      <= ARL_ST_BUSY;
            addr       <= mreq_i.addr;
            wbuf       <= wjust;
            wr_q       <= mreq_i.wr && !mreq_i.fetch;
            beats_left <= nbeats;
            single     <= byte_beat;
            rbuf       <= arl_pkg::ZERO32;
          end
        end
        ARL_ST_BUSY: begin
          if (mem_ack_i) begin
            // High part first, next part at the next higher address
            if (single) begin
              rbuf <= {rbuf[23:0], rb8};
              wbuf <= {wbuf[23:0], 8'h00};
              addr <= addr + arl_pkg::STEP_BYTE;
            end else begin
              rbuf <= {rbuf[15:0], rb16};
              wbuf <= {wbuf[15:0], 16'h0000};
              addr <= addr + arl_pkg::LONG_HALF;
            end
            beats_left <= beats_left - 3'd1;
            if (beats_left == 3'd1) begin
              state   <= ARL_ST_IDLE;
              rdone_o <= !wr_q;
              rdata_o <= single ? {rbuf[23:0], rb8} : {rbuf[15:0], rb16};
            end
          end
        end
        default: state <= ARL_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_stop_cmd;
    stop_i && !irq_s;
  endsequence
  sequence s_last_beat;
    mem_vld_o && mem_ack_i && beats_left == 3'd1;
  endsequence
  a_stop_enter: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_stop_cmd |=> stopped_o)
    else $error("stop not entered");
  a_beat_done: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_last_beat |=> (!mem_vld_o && (rdone_o == !$past(mem_wr_o))))
    else $error("transfer did not end after last beat");
  a_odd_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    (take && odd_bad) |=> (align_err_o && state == ARL_ST_IDLE))
    else $error("odd access not flagged");
  a_even_only: assert property (@(posedge clk_i) disable iff (!rst_n)
    (mem_vld_o && !single) |-> !mem_addr_o[0])
    else $error("multibyte beat at odd address");
  a_long_step: assert property (@(posedge clk_i) disable iff (!rst_n)
    (mem_vld_o && mem_ack_i && !single && beats_left == 3'd2) |=> (mem_addr_o == $past(mem_addr_o) + 32'd2))
    else $error("second word not at n+2");
  a_stop_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    (stopped_o && !irq_s) |=> stopped_o)
    else $error("stop left without interrupt");
  a_stop_wake: assert property (@(posedge clk_i) disable iff (!rst_n)
    (stopped_o && irq_s) |=> !stopped_o)
    else $error("interrupt did not wake");
  a_cond_nop: assert property (@(posedge clk_i) disable iff (!rst_n)
    (req_vld_i && cond_skip) |-> !reg_wr)
    else $error("skipped conditional wrote");
  a_cond_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    (req_vld_i && cond_skip && !is_sp) |=> (areg[$past(req_i.idx)] == $past(cur)))
    else $error("skipped conditional changed register");
  a_byte_refuse: assert property (@(posedge clk_i) disable iff (!rst_n)
    (req_vld_i && byte_direct && !stopped_o && !cond_skip) |=> size_err_o)
    else $error("byte size not refused");
  a_word_sext: assert property (@(posedge clk_i) disable iff (!rst_n)
    (reg_wr && !is_sp && req_i.amode == arl_pkg::ARL_AM_NONE && req_i.size == arl_pkg::ARL_SZ_WORD)
      |=> (areg[$past(req_i.idx)] == {{16{$past(req_i.data[15])}}, $past(req_i.data[15:0])}))
    else $error("word write not sign-extended");
  a_sp_byte: assert property (@(posedge clk_i) disable iff (!rst_n)
    (reg_wr && is_sp && !supv_i && is_byte && req_i.amode == arl_pkg::ARL_AM_POSTINC)
      |=> (user_stack_pointer == $past(user_stack_pointer) + 32'd2))
    else $error("stack byte step not two");
  a_word_read: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_size_i == arl_pkg::ARL_SZ_WORD) |-> (rd_data_o[15:0] == rd_full[15:0]))
    else $error("word read not low half");
endmodule : arl_core

// *** test/arl_mem_model.sv ***
// Behavioural memory on the processor bus, big-endian bytes
`timescale 1ns/1ps
module arl_mem_model #(
  parameter int W = 16                    // Bus width, 16 or 8
) (
  input  wire logic         clk_i,   // Clock
  input  wire logic         vld_i,   // Beat request
  input  wire logic         wr_i,    // Beat is a write
  input  wire logic [31:0]  addr_i,  // Byte address
  input  wire logic [W-1:0] wdata_i, // Write data
  input  wire logic         slow_i,  // Insert wait cycles
  output logic [W-1:0]      rdata_o, // Read data
  output logic              ack_o    // Beat done
);
  logic [7:0] mem [0:511];
  logic [1:0] wait_cnt;
  wire  [8:0] a = addr_i[8:0];
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'(i * 59);
    ack_o = 1'b0;
    rdata_o = '0;
    wait_cnt = '0;
  end
  // Idle lines toggle so a stale value never passes for an answer
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (vld_i && !ack_o) begin
      if (slow_i && wait_cnt != 2'd3) wait_cnt <= wait_cnt + 2'd1;
      else begin
        wait_cnt <= 2'd0;
        ack_o <= 1'b1;
        if (W == 16) begin
          rdata_o <= W'({mem[{a[8:1], 1'b0}], mem[{a[8:1], 1'b1}]});
          if (wr_i) {mem[{a[8:1], 1'b0}], mem[{a[8:1], 1'b1}]} <= 16'(wdata_i);
        end else begin
          rdata_o <= W'(mem[a]);
          if (wr_i) mem[a] <= 8'(wdata_i);
        end
      end
    end
  end
endmodule : arl_mem_model

// *** test/addr_reg_and_memory_layout_test.sv ***
// Self-checking bench for the address register and memory layout block
`timescale 1ns/1ps
module addr_reg_and_memory_layout_test;
  localparam arl_pkg::arl_size_t SB = arl_pkg::ARL_SZ_BYTE, SW = arl_pkg::ARL_SZ_WORD, SL = arl_pkg::ARL_SZ_LONG;
  localparam arl_pkg::arl_amode_t AN = arl_pkg::ARL_AM_NONE, AI = arl_pkg::ARL_AM_POSTINC, AD = arl_pkg::ARL_AM_PREDEC;
  logic clk_i, rst_n_i, req_vld_i, supv_i, mreq_vld_i, stop_i, irq_i, slow;
  arl_pkg::arl_req_t req_i;
  arl_pkg::arl_mreq_t mreq_i;
  arl_pkg::arl_size_t rd_size_i;
  logic [2:0] rd_idx_i;
  logic [7:0] bcd_i, wd8, rd8;
  logic [31:0] rd_data_o, mem_addr_o, rdata_o, addr8, rdata8, seed, b;
  logic size_err_o, mreq_rdy_o, align_err_o, mem_vld_o, mem_wr_o, mem_ack_i, rdone_o, stopped_o;
  logic rdy8, vld8, wr8, ack8, rdone8;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  logic [3:0] most_significant_digit_o, least_significant_digit_o;
  logic [33:0] expq[$];
  logic [31:0] exp8[$];
  int fail_count = 0, samples_checked = 0, beats = 0;

  arl_core arl_core_i (.*);
  arl_core #(.MEM_BUS_W(8)) arl_core_b8_i (.*, .rd_data_o(), .size_err_o(), .mreq_rdy_o(rdy8), .align_err_o(),
    .mem_vld_o(vld8), .mem_addr_o(addr8), .mem_wr_o(wr8), .mem_wdata_o(wd8), .mem_rdata_i(rd8),
    .mem_ack_i(ack8), .rdone_o(rdone8), .rdata_o(rdata8), .most_significant_digit_o(),
    .least_significant_digit_o(), .stopped_o());
  arl_mem_model arl_mem_model_i (.clk_i(clk_i), .vld_i(mem_vld_o), .wr_i(mem_wr_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .slow_i(slow), .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
  arl_mem_model #(.W(8)) arl_mem_model_b8_i (.clk_i(clk_i), .vld_i(vld8), .wr_i(wr8), .addr_i(addr8),
    .wdata_i(wd8), .slow_i(slow), .rdata_o(rd8), .ack_o(ack8));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic take(input logic [1:0] k, input logic [31:0] v);
    chk("result", (expq.size() != 0) ? expq.pop_front() : 34'h3_ffff_ffff, {k, v});
  endtask : take
  // c = {wr, cond_op, cond_true, has_else}
  task automatic rop(input logic [3:0] c, input logic [2:0] i, input arl_pkg::arl_size_t s,
                     input arl_pkg::arl_amode_t m, input logic [31:0] d);
    @(negedge clk_i);
    req_i = {c, i, s, m, d};
    req_vld_i = 1'b1;
    @(negedge clk_i);
    req_vld_i = 1'b0;
  endtask : rop
  task automatic rchk(input logic [2:0] i, input arl_pkg::arl_size_t s, input logic [31:0] e);
    rd_idx_i = i;
    rd_size_i = s;
    #1;
    chk("register", {2'b00, e}, {2'b00, rd_data_o});
  endtask : rchk
  // k: 0 read data, 2 alignment refusal, 3 nothing
  task automatic mop(input logic [1:0] f, input arl_pkg::arl_size_t s, input logic [31:0] a,
                     input logic [31:0] d, input logic [1:0] k, input logic [31:0] e);
    @(negedge clk_i);
    if (k != 2'd3) expq.push_back({k, e});
    if (k == 2'd0) exp8.push_back(e);
    mreq_i = {f, s, a, d};
    mreq_vld_i = 1'b1;
    @(negedge clk_i);
    mreq_vld_i = 1'b0;
    for (int i = 0; i < 300 && !(mreq_rdy_o && rdy8); i++) @(negedge clk_i);
    chk("ready", 2'b11, {mreq_rdy_o, rdy8});
  endtask : mop
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk_i) if (rst_n_i) begin
    if (rdone_o) take(2'd0, rdata_o);
    if (size_err_o) take(2'd1, 32'h0000_0000);
    if (align_err_o) take(2'd2, 32'h0000_0000);
    if (rdone8) chk("rdata8", {2'b00, exp8.pop_front()}, {2'b00, rdata8});
  end
  always @(posedge clk_i) if (mem_vld_o && mem_ack_i) beats++;
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    test_done();
  end

  initial begin
    {rst_n_i, req_vld_i, mreq_vld_i, stop_i, irq_i, slow, rd_idx_i, bcd_i} = '0;
    {req_i, mreq_i} = '0;
    supv_i = 1'b1;
    rd_size_i = SL;
    seed = 32'h5074;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    seed = lfsr(seed);
    rop(4'b1000, 3'd1, SL, AN, seed);
    rchk(3'd1, SL, seed);
    rchk(3'd1, SW, {{16{seed[15]}}, seed[15:0]});
    rop(4'b1000, 3'd2, SW, AN, 32'h1234_8001);
    rchk(3'd2, SL, 32'hffff_8001);
    rop(4'b1000, 3'd3, SL, AN, 32'h1234_7ffe);
    rchk(3'd3, SW, 32'h0000_7ffe);
    expq.push_back({2'd1, 32'h0000_0000});
    rop(4'b1000, 3'd3, SB, AN, 32'h0000_0000);
    rchk(3'd3, SL, 32'h1234_7ffe);
    rop(4'b1100, 3'd3, SL, AN, 32'h0000_0000);
    rchk(3'd3, SL, 32'h1234_7ffe);
    rop(4'b1110, 3'd3, SL, AN, 32'h0000_0044);
    rchk(3'd3, SL, 32'h0000_0044);
    rop(4'b1101, 3'd3, SL, AN, 32'h0000_0055);
    rchk(3'd3, SL, 32'h0000_0055);
    rop(4'b0000, 3'd3, SB, AI, 32'h0000_0000);
    rop(4'b0000, 3'd3, SL, AD, 32'h0000_0000);
    rchk(3'd3, SL, 32'h0000_0052);
    rop(4'b1000, 3'd7, SL, AN, 32'h0000_0100);
    supv_i = 1'b0;
    rop(4'b1000, 3'd7, SL, AN, 32'h0000_0200);
    rchk(3'd7, SL, 32'h0000_0200);
    rop(4'b0000, 3'd7, SB, AI, 32'h0000_0000);
    rchk(3'd7, SL, 32'h0000_0202);
    supv_i = 1'b1;
    rop(4'b0000, 3'd7, SB, AI, 32'h0000_0000);
    rchk(3'd7, SL, 32'h0000_0102);
    rop(4'b0000, 3'd7, SB, AD, 32'h0000_0000);
    rchk(3'd7, SL, 32'h0000_0100);
    for (int r = 0; r < 2; r++) begin
      slow = r[0];
      seed = lfsr(seed);
      mop(2'b01, SL, 32'h0000_0100, seed, 2'd3, 32'h0);
      mop(2'b00, SL, 32'h0000_0100, 32'h0, 2'd0, seed);
      mop(2'b00, SW, 32'h0000_0102, 32'h0, 2'd0, {16'h0000, seed[15:0]});
      mop(2'b00, SB, 32'h0000_0101, 32'h0, 2'd0, {24'h00_0000, seed[23:16]});
      mop(2'b00, SB, 32'h0000_0100, 32'h0, 2'd0, {24'h00_0000, seed[31:24]});
      mop(2'b10, SW, 32'h0000_0100, 32'h0, 2'd0, {16'h0000, seed[31:16]});
      mop(2'b01, SW, 32'h0000_0104, seed, 2'd3, 32'h0);
      mop(2'b00, SL, 32'h0000_0104, 32'h0, 2'd0, {seed[15:0], 8'(262 * 59), 8'(263 * 59)});
      chk("bytes", seed, {arl_mem_model_i.mem[256], arl_mem_model_i.mem[257],
        arl_mem_model_i.mem[258], arl_mem_model_i.mem[259]});
      for (int i = 256; i < 264; i++) chk("bus8", arl_mem_model_i.mem[i], arl_mem_model_b8_i.mem[i]);
    end
    b = beats;
    mop(2'b00, SW, 32'h0000_0103, 32'h0, 2'd2, 32'h0);
    mop(2'b10, SW, 32'h0000_0101, 32'h0, 2'd2, 32'h0);
    mop(2'b01, SL, 32'h0000_0105, seed, 2'd2, 32'h0);
    repeat (3) @(negedge clk_i);
    chk("beats", b, beats);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bcd_i = seed[7:0];
      #1;
      chk("digits", seed[7:0], {most_significant_digit_o, least_significant_digit_o});
    end
    @(negedge clk_i);
    stop_i = 1'b1;
    @(negedge clk_i);
    stop_i = 1'b0;
    @(negedge clk_i);
    chk("stopped", 2'b01, {mreq_rdy_o, stopped_o});
    rop(4'b1000, 3'd3, SL, AN, 32'h0000_0099);
    repeat (5) @(negedge clk_i);
    chk("stopped", 1'b1, stopped_o);
    rchk(3'd3, SL, 32'h0000_0052);
    irq_i = 1'b1;
    for (int i = 0; i < 6 && stopped_o; i++) @(negedge clk_i);
    irq_i = 1'b0;
    chk("stopped", 1'b0, stopped_o);
    mop(2'b00, SL, 32'h0000_0100, 32'h0, 2'd0, {arl_mem_model_i.mem[256], arl_mem_model_i.mem[257],
      arl_mem_model_i.mem[258], arl_mem_model_i.mem[259]});
    repeat (4) @(negedge clk_i);
    chk("pending", 0, expq.size() + exp8.size());
    test_done();
  end
endmodule : addr_reg_and_memory_layout_test
